//--- shared/tcce_pkg.sv
// constants, register indices and field layout of the timer
// compare/capture/event block.
// assumes a 32-bit AXI4-Lite register bus, one word per register.
package tcce_pkg;

  // ------------------------------------------------------------
  // addressing: index = printed offset, byte address = 4 * index
  // ------------------------------------------------------------
  localparam int AW = 13;               // byte address width
  localparam int IW = 11;               // word index width
  localparam logic [IW-1:0] IDX_MODE  = 11'h400;
  localparam logic [IW-1:0] IDX_XMODE = 11'h402;
  localparam logic [IW-1:0] IDX_EVENT = 11'h403;
  localparam logic [IW-1:0] IDX_REF   = 11'h404;
  localparam logic [IW-1:0] IDX_CAP   = 11'h408;
  localparam logic [IW-1:0] IDX_CNT   = 11'h40c;
  localparam logic [IW-1:0] IDX_MASK  = 11'h410;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int XM_DMA   = 7;          // transfer_request_enable
  localparam int XM_HALT  = 6;          // stop while core halted
  localparam int XM_WIDE  = 0;          // wide_step_mode
  localparam int EV_REF   = 1;          // match flag
  localparam int EV_CAP   = 0;          // edge_latched_flag
  localparam int MD_CE    = 6;          // low bit of edge select
  localparam int MD_MATCH_REQUEST_ENABLE  = 4;          // match_request_enable
  localparam int MD_FRR   = 3;          // restart_on_match
  localparam int MD_RUN   = 0;          // counter enable

  // ------------------------------------------------------------
  // codes and reset values
  // ------------------------------------------------------------
  localparam logic [1:0]  CE_REF    = 2'h0;
  localparam logic [1:0]  CE_RISE   = 2'h1;
  localparam logic [1:0]  CE_FALL   = 2'h2;
  localparam logic [1:0]  CE_ANY    = 2'h3;
  localparam logic [15:0] RST_MODE  = 16'h0000;
  localparam logic [7:0]  RST_XMODE = 8'h00;
  localparam logic [1:0]  RST_FLAGS = 2'h0;
  localparam logic [1:0]  RST_MASK  = 2'h3;
  localparam logic [31:0] RST_REF   = 32'hffffffff;
  localparam logic [31:0] RST_CAP   = 32'h00000000;
  localparam logic [31:0] STEP_ONE  = 32'h00000001;
  localparam logic [31:0] STEP_WIDE = 32'h00010001;
  localparam logic [7:0]  XM_USED   = 8'hc1;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  // byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] tcce_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = new_w[8*i +: 8];
    return r;
  endfunction

endpackage

//--- shared/tcce_reg_if.sv
// register access strobes between the bus slave and the registers.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tcce_reg_if;
  import tcce_pkg::*;
  logic          wr;      // one-cycle write strobe
  logic [IW-1:0] waddr;   // write word index
  logic [31:0]   wdata;   // write data
  logic [3:0]    wstrb;   // byte enables
  logic [IW-1:0] raddr;   // read word index
  logic [31:0]   rdata;   // read data, combinational
  logic          whit;    // write index is mapped
  logic          rhit;    // read index is mapped
  modport bus  (output wr, waddr, wdata, wstrb, raddr,
                input  rdata, whit, rhit);
  modport regs (input  wr, waddr, wdata, wstrb, raddr,
                output rdata, whit, rhit);
endinterface
`default_nettype wire

//--- rtl/tcce_edge.sv
// edge detector on the timer input pin for the capture path.
// assumes the pin is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module tcce_edge
  import tcce_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // pin and selection
  input  wire logic       pin,
  input  wire logic [1:0] sel,
  // result
  output logic            hit
);
  typedef struct packed {
    logic armed;   // one sample taken since reset
    logic prev;    // pin one cycle ago
  } tcce_edge_st_t;
  tcce_edge_st_t s_q, s_d;

  // armed guards against a false edge right after reset
  always_comb
  begin
    s_d       = s_q;
    s_d.armed = 1'b1;
    s_d.prev  = pin;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // chosen transition only; edge select 00 never hits
  always_comb
  begin
    hit = 1'b0;
    if (s_q.armed)
      case (sel)
        CE_RISE: hit = pin & ~s_q.prev;
        CE_FALL: hit = ~pin & s_q.prev;
        CE_ANY:  hit = pin ^ s_q.prev;
        default: hit = 1'b0;
      endcase
  end
endmodule
`default_nettype wire

//--- rtl/tcce_axil.sv
// AXI4-Lite slave: turns bus transfers into register strobes.
// assumes one write and one read outstanding at most.
`timescale 1ns/1ps
`default_nettype none
module tcce_axil
  import tcce_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // write channels
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // read channels
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // register side
  tcce_reg_if.bus            rif
);
  typedef struct packed {
    logic aw_got; logic w_got; logic [AW-1:0] waddr;
    logic [31:0] wdata; logic [3:0] wstrb;
    logic bvalid; logic [1:0] bresp; logic awrdy; logic wrdy;
    logic ar_pend; logic [AW-1:0] raddr; logic arrdy;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } tcce_axil_st_t;
  tcce_axil_st_t s_q, s_d;
  logic do_wr;

  // write fires once address and data are both held
  assign do_wr = s_q.aw_got & s_q.w_got & ~s_q.bvalid;

  always_comb
  begin
    s_d = s_q;
    if (s_q.awrdy && awvalid)
    begin
      s_d.aw_got = 1'b1;
      s_d.waddr  = awaddr;
    end
    if (s_q.wrdy && wvalid)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready)
      s_d.bvalid = 1'b0;
    if (do_wr)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = rif.whit ? RESP_OK : RESP_ERR;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
    end
    if (s_q.arrdy && arvalid)
    begin
      s_d.ar_pend = 1'b1;
      s_d.raddr   = araddr;
    end
    if (s_q.rvalid && rready)
      s_d.rvalid = 1'b0;
    // unmapped reads answer zero with an error response
    if (s_q.ar_pend)
    begin
      s_d.ar_pend = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = rif.rhit ? rif.rdata : 32'h00000000;
      s_d.rresp   = rif.rhit ? RESP_OK : RESP_ERR;
    end
    s_d.awrdy = ~s_d.aw_got & ~s_d.bvalid;
    s_d.wrdy  = ~s_d.w_got & ~s_d.bvalid;
    s_d.arrdy = ~s_d.ar_pend & ~s_d.rvalid;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rif.wr    = do_wr;
  assign rif.waddr = s_q.waddr[AW-1:2];
  assign rif.wdata = s_q.wdata;
  assign rif.wstrb = s_q.wstrb;
  assign rif.raddr = s_q.raddr[AW-1:2];
  assign awready   = s_q.awrdy;
  assign wready    = s_q.wrdy;
  assign bvalid    = s_q.bvalid;
  assign bresp     = s_q.bresp;
  assign arready   = s_q.arrdy;
  assign rvalid    = s_q.rvalid;
  assign rdata     = s_q.rdata;
  assign rresp     = s_q.rresp;
endmodule
`default_nettype wire

//--- rtl/tcce_top.sv
// timer compare, capture and event flags with request routing.
// assumes a prescaled tick pulse from outside and a pin input
// synchronous to clk; registers are reached over AXI4-Lite.
//
// Function
// (RQ1) ext mode bit 7 routes events to DMA
// (RQ2) ext mode bit 6 freezes counter on halt
// (RQ3) halt freeze only in reference compare mode
// (RQ4) bit 0 selects step 1 or 65,537
// (RQ5) wide step still compares all 32 bits
// (RQ6) flags set regardless of any enables
// (RQ7) write one clears flag, both together allowed
// (RQ8) handler clears flags early to drop interrupt
// (RQ9) DMA acknowledge clears both flags
// (RQ10) bit 1 match flag, bit 0 capture flag
// (RQ11) capture flag requests when edge select nonzero
// (RQ12) edge select 00 gives no capture request
// (RQ13) match when equal and next tick arrives
// (RQ14) selected pin edge copies counter to capture
// (RQ15) pin must not clock counter during capture
// (RQ16) match request gated by match request enable
// (RQ17) restart returns counter to zero on match
// (RQ18) request outputs are levels following the flags
`timescale 1ns/1ps
`default_nettype none
module tcce_top
  import tcce_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // axi4-lite write channels
  input  wire logic [tcce_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read channels
  input  wire logic [tcce_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // timing inputs
  input  wire logic                   tick,
  input  wire logic                   core_halted,
  input  wire logic                   timer_input_pin,
  // dma handshake and requests
  input  wire logic                   dma_ack,
  output logic                        dma_req,
  output logic                        irq,
  // counter view for the output stage
  output logic [31:0]                 count_value,
  output logic                        match_pulse
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] mode;    // primary_mode_reg
    logic [7:0]  xmode;   // extended_mode_reg
    logic [1:0]  flags;   // event_flags_reg
    logic [1:0]  mask;    // interrupt mask, same layout
    logic [31:0] ref_v;   // match_value_reg
    logic [31:0] cap_v;   // latched_count_reg
    logic [31:0] cnt;     // count_value
    logic        irq;     // interrupt request level
    logic        dma;     // dma request level
    logic        match;   // one-cycle match event
  } tcce_top_st_t;

  tcce_top_st_t s_q, s_d;
  tcce_reg_if   rif ();

  logic [1:0]  ce;        // edge select field
  logic        dma_en;    // transfer_request_enable
  logic        stop;      // halt freeze in effect
  logic        go;        // counter advances this cycle
  logic        eq;        // full 32-bit compare
  logic [31:0] step;      // increment per tick
  logic        cap_hit;   // selected pin transition
  logic        wr_cnt;    // software write to the counter
  logic        wr_ev;     // software write to event flags
  logic [1:0]  w1c;       // flags cleared by software
  logic [1:0]  ack_clr;   // flags cleared by dma acknowledge

  // ------------------------------------------------------------
  // bus slave and pin edge detector
  // ------------------------------------------------------------
  tcce_axil u_axil (
    .clk     (clk),
    .rst_b   (rst_b),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rif     (rif)
  );

  tcce_edge u_edge (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (timer_input_pin),
    .sel   (ce),
    .hit   (cap_hit)  // RQ14
  );

  // ------------------------------------------------------------
  // decoded controls
  // ------------------------------------------------------------
  assign ce     = s_q.mode[MD_CE +: 2];
  assign dma_en = s_q.xmode[XM_DMA];
  // freeze only counts in reference mode; capture ignores it
  assign stop   = s_q.xmode[XM_HALT] & core_halted
                & (ce == CE_REF);                  // RQ2 RQ3
  assign go     = s_q.mode[MD_RUN] & tick & ~stop;
  // upper half is not masked off in wide mode
  assign eq     = (s_q.cnt == s_q.ref_v);          // RQ5
  assign step   = s_q.xmode[XM_WIDE] ? STEP_WIDE
                                     : STEP_ONE;   // RQ4
  assign wr_cnt = rif.wr & (rif.waddr == IDX_CNT);
  assign wr_ev  = rif.wr & (rif.waddr == IDX_EVENT);
  assign w1c    = wr_ev ? (rif.wdata[1:0] & {2{rif.wstrb[0]}})
                        : 2'h0;                    // RQ7
  assign ack_clr = (dma_ack & dma_en) ? 2'h3 : 2'h0; // RQ9

  // ------------------------------------------------------------
  // register map decode
  // ------------------------------------------------------------
  // unmapped indices raise the error response in the slave
  always_comb
  begin
    rif.whit = 1'b1;
    case (rif.waddr)
      IDX_MODE, IDX_XMODE, IDX_EVENT, IDX_REF,
      IDX_CAP, IDX_CNT, IDX_MASK: rif.whit = 1'b1;
      default:                    rif.whit = 1'b0;
    endcase
  end

  // reads show live state; reserved bits read zero
  always_comb
  begin
    rif.rhit  = 1'b1;
    rif.rdata = 32'h00000000;
    case (rif.raddr)
      IDX_MODE:  rif.rdata = {16'h0000, s_q.mode};
      IDX_XMODE: rif.rdata = {24'h000000, s_q.xmode};
      IDX_EVENT: rif.rdata = {30'h0, s_q.flags};
      IDX_REF:   rif.rdata = s_q.ref_v;
      IDX_CAP:   rif.rdata = s_q.cap_v;
      IDX_CNT:   rif.rdata = s_q.cnt;
      IDX_MASK:  rif.rdata = {30'h0, s_q.mask};
      default:   rif.rhit  = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    logic [31:0] mrg;
    logic [31:0] mrg_m;
    logic        ref_rq;
    logic        cap_rq;
    s_d       = s_q;
    s_d.match = 1'b0;
    ref_rq    = 1'b0;
    cap_rq    = 1'b0;
    mrg       = tcce_merge(32'h00000000, rif.wdata, rif.wstrb);
    // mode keeps its own bytes where the strobe is low
    mrg_m     = tcce_merge({16'h0000, s_q.mode}, rif.wdata, rif.wstrb);

    // software writes to the plain registers
    if (rif.wr)
      case (rif.waddr)
        IDX_MODE:
          s_d.mode = mrg_m[15:0];
        IDX_XMODE:
          // reserved bits stay clear
          if (rif.wstrb[0])
            s_d.xmode = mrg[7:0] & XM_USED;
        IDX_REF:
          s_d.ref_v = tcce_merge(s_q.ref_v, rif.wdata,
                                 rif.wstrb);
        IDX_CAP:
          s_d.cap_v = tcce_merge(s_q.cap_v, rif.wdata,
                                 rif.wstrb);
        IDX_MASK:
          if (rif.wstrb[0])
            s_d.mask = mrg[1:0];
        default:
          s_d.mode = s_q.mode;
      endcase

    // counter: compare happens as the next tick arrives
    if (go)
    begin
      if (eq)
      begin
        s_d.match = 1'b1;                          // RQ13
        s_d.cnt   = s_q.mode[MD_FRR] ? 32'h00000000
                                     : s_q.cnt + step; // RQ17
      end
      else
        s_d.cnt = s_q.cnt + step;                  // RQ4
    end
    // any write clears the counter and beats the tick
    if (wr_cnt)
      s_d.cnt = 32'h00000000;

    // a capture edge overrides a same-cycle software write
    if (cap_hit)
      s_d.cap_v = s_q.cnt;                         // RQ14

    // set beats clear so no event is lost
    s_d.flags = (s_q.flags & ~(w1c | ack_clr))     // RQ7 RQ9
              | {s_d.match, cap_hit};              // RQ6 RQ10

    // request routing from the next flags, so the outputs
    // track the flags in the same cycle they change
    ref_rq = s_d.flags[EV_REF] & s_d.mode[MD_MATCH_REQUEST_ENABLE]; // RQ16
    cap_rq = s_d.flags[EV_CAP]
           & (s_d.mode[MD_CE +: 2] != CE_REF);     // RQ11 RQ12
    s_d.dma = s_d.xmode[XM_DMA] & (ref_rq | cap_rq); // RQ1
    s_d.irq = ~s_d.xmode[XM_DMA]
            & |({ref_rq, cap_rq} & s_d.mask);      // RQ1 RQ18
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_q       <= '0;
      s_q.mode  <= RST_MODE;
      s_q.xmode <= RST_XMODE;
      s_q.flags <= RST_FLAGS;
      s_q.mask  <= RST_MASK;
      s_q.ref_v <= RST_REF;
      s_q.cap_v <= RST_CAP;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from the state register
  assign irq         = s_q.irq;
  assign dma_req     = s_q.dma;
  assign count_value = s_q.cnt;
  assign match_pulse = s_q.match;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence seq_match_now;
    go && eq && !wr_cnt;
  endsequence

  sequence seq_quiet_flags;
    !go && !cap_hit;
  endsequence

  a_match_flag_set: // RQ10
    assert property (seq_match_now |=> s_q.match
                     && s_q.flags[EV_REF])
    else $error("match flag not set on compare");

  a_restart_zero: // RQ17
    assert property (seq_match_now ##0 s_q.mode[MD_FRR]
                     |=> s_q.cnt == 32'h00000000)
    else $error("counter not restarted on match");

  a_wide_step_add: // RQ4
    assert property (go && !eq && !wr_cnt
                     && s_q.xmode[XM_WIDE]
                     |=> s_q.cnt == $past(s_q.cnt) + STEP_WIDE)
    else $error("wide step increment wrong");

  a_full_compare: // RQ5
    assert property (go && s_q.xmode[XM_WIDE]
                     && s_q.cnt[15:0] == s_q.ref_v[15:0]
                     && s_q.cnt[31:16] != s_q.ref_v[31:16]
                     |=> !s_q.match)
    else $error("match on lower half only");

  a_halt_freeze: // RQ2 RQ3
    assert property (s_q.xmode[XM_HALT] && core_halted
                     && ce == CE_REF && !wr_cnt
                     |=> s_q.cnt == $past(s_q.cnt))
    else $error("counter moved while core halted");

  a_capture_copy: // RQ14 RQ6
    assert property (cap_hit |=> s_q.cap_v == $past(s_q.cnt)
                     && s_q.flags[EV_CAP])
    else $error("capture did not latch counter");

  a_w1c_clear: // RQ7
    assert property (wr_ev && rif.wstrb[0]
                     && rif.wdata[1:0] == 2'h3
                     ##0 seq_quiet_flags ##1 seq_quiet_flags
                     |-> (s_q.flags == 2'h0) [*2])
    else $error("write one did not clear flags");

  a_ack_clear: // RQ9
    assert property (dma_ack && dma_en ##0 seq_quiet_flags
                     |=> s_q.flags == 2'h0)
    else $error("dma acknowledge did not clear flags");

  a_dma_route: // RQ1
    assert property (s_q.dma |-> dma_en && !s_q.irq)
    else $error("dma request while routed to irq");

  a_cap_ref_mode: // RQ12
    assert property (s_q.flags == 2'h1 && ce == CE_REF
                     |-> !s_q.irq && !s_q.dma)
    else $error("request from capture in reference mode");

  a_cap_irq_level: // RQ11 RQ18
    assert property (s_q.flags[EV_CAP] && ce != CE_REF
                     && !dma_en && s_q.mask[EV_CAP]
                     |-> s_q.irq)
    else $error("capture interrupt missing");

  a_ref_gate: // RQ16
    assert property (s_q.flags == 2'h2
                     |-> s_q.dma == (dma_en
                         && s_q.mode[MD_MATCH_REQUEST_ENABLE]))
    else $error("match request gating wrong");

endmodule
`default_nettype wire

//--- test/tcce_dma_model.sv
// dma controller model: answers a standing request with an ack.
// assumes dma_req is a level that drops once the flags clear.
`timescale 1ns/1ps
`default_nettype none
module tcce_dma_model #(
  parameter int DLY = 3            // ack comes DLY+1 cycles after the request
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // handshake
  input  wire logic en,            // bench lets the model answer
  input  wire logic dma_req,
  output logic      dma_ack
);
  int n;                           // wait counter
  // a slow answer lets the bench see the request level first
  always @(posedge clk)
    if (!rst_b || !en || !dma_req || dma_ack)
    begin
      n <= 0;
      dma_ack <= 1'b0;
    end
    else
    begin
      n <= n + 1;
      dma_ack <= (n == DLY);
    end
endmodule
`default_nettype wire

//--- test/tb.sv
// testbench of the timer compare/capture block over AXI4-Lite.
// assumes the dma model as the far side; irq is watched directly.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tcce_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic          clk, rst_b, awv, wv, arv, tick, halt, dm_en;
  logic          pin;              // capture only, never a clock
  logic [AW-1:0] aw, ar;
  logic [31:0]   wd, rd_v, cnt, rdat;
  logic          awr, wr_r, bv, arr, rv, ack, dreq, irq, mp;
  logic [1:0]    br, rr;
  int            err_total, total_checks, mc;
  // row: edge select, dma route, final pin level, irq, dma_req
  typedef struct packed
  {logic [1:0] ce; logic dma, lvl, irq, dreq;} tcce_row_t;
  tcce_row_t     r;
  tcce_row_t     rows [6] = '{6'h16, 6'h29, 6'h36, 6'h39, 6'h04, 6'h08};

  tcce_top DUT (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_v), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .tick(tick), .core_halted(halt),
    .timer_input_pin(pin), .dma_ack(ack), .dma_req(dreq), .irq(irq),
    .count_value(cnt), .match_pulse(mp));
  tcce_dma_model #(.DLY(3)) dma (.clk(clk), .rst_b(rst_b),
    .en(dm_en), .dma_req(dreq), .dma_ack(ack));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // both channels offered together; each dropped once taken
  task automatic wr(input logic [IW-1:0] i, input logic [31:0] d);
    aw <= {i, 2'h0};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
  endtask
  task automatic rd(input logic [IW-1:0] i);
    ar <= {i, 2'h0};
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rdat = rd_v;
  endtask
  // one tick per two cycles; match pulses are counted
  task automatic tk(input int k);
    repeat (k)
    begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
      mc = mc + int'(mp === 1'b1);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // the whole run needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    results;
  end
  initial
  begin
    {rst_b, awv, wv, arv, tick, halt, pin, dm_en} = 8'h00;
    {aw, ar, wd} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(IDX_EVENT);
    chk("flags rst", rdat, 32'h0);
    rd(IDX_XMODE);
    chk("xmode rst", rdat, 32'h0);
    rd(IDX_REF);
    chk("ref rst", rdat, RST_REF);
    rd(11'h7ff);
    chk("unmapped", {30'h0, rr}, {30'h0, RESP_ERR});
    wr(11'h7ff, 32'h0);
    chk("wr err", {30'h0, br}, {30'h0, RESP_ERR});
    // capture routing table, model held off so flags stay up
    foreach (rows[k])
    begin
      r = rows[k];
      wr(IDX_MODE, 32'h0);
      chk("ref mode", {30'h0, irq, dreq}, 32'h0);
      wr(IDX_EVENT, 32'h1);
      pin <= ~r.lvl;
      wr(IDX_XMODE, {24'h0, r.dma, 7'h0});
      wr(IDX_MODE, {24'h0, r.ce, 6'h0});
      pin <= r.lvl;
      repeat (3) @(posedge clk);
      chk("irq", irq, r.irq);
      chk("dma_req", dreq, r.dreq);
      rd(IDX_EVENT);
      chk("cap flag", rdat, {31'h0, r.ce != CE_REF});
    end
    // compare with restart: match on the fourth tick for ref 3
    wr(IDX_XMODE, 32'h0);
    wr(IDX_CNT, 32'h0);
    chk("wr ok", {30'h0, br}, {30'h0, RESP_OK});
    wr(IDX_REF, 32'h3);
    wr(IDX_MODE, 32'h19);
    mc = 0;
    tk(3);
    chk("early", mc, 32'h0);
    tk(1);
    chk("match", mc, 32'h1);
    chk("restart", cnt, 32'h0);
    chk("irq ref", irq, 32'h1);
    wr(IDX_MODE, 32'h59);
    pin <= 1'b1;
    wr(IDX_EVENT, 32'h0);
    rd(IDX_EVENT);
    chk("w0 keeps", rdat, 32'h3);
    wr(IDX_EVENT, 32'h3);
    rd(IDX_EVENT);
    chk("w1c both", rdat, 32'h0);
    chk("irq drop", irq, 32'h0);
    // wide step: lower halves alike but full words differ
    wr(IDX_MODE, 32'h11);
    wr(IDX_CNT, 32'h0);
    wr(IDX_REF, 32'h1);
    wr(IDX_XMODE, 32'h1);
    mc = 0;
    tk(2);
    chk("wide", cnt, 32'h00020002);
    chk("wide cmp", mc, 32'h0);
    // halt freeze only in reference mode
    wr(IDX_XMODE, 32'h40);
    wr(IDX_MODE, 32'h01);
    wr(IDX_CNT, 32'h0);
    halt <= 1'b1;
    tk(2);
    chk("halt hold", cnt, 32'h0);
    wr(IDX_MODE, 32'h41);
    tk(1);
    chk("halt cap", cnt, 32'h1);
    wr(IDX_XMODE, 32'h0);
    wr(IDX_MODE, 32'h01);
    tk(1);
    chk("halt off", cnt, 32'h2);
    halt <= 1'b0;
    // a pin edge overwrites what software left in the latch
    wr(IDX_CAP, 32'h5);
    wr(IDX_MODE, 32'hc1);
    pin <= 1'b0;
    rd(IDX_CAP);
    chk("latched", rdat, 32'h2);
    // dma route: request, then the ack clears the flags
    wr(IDX_EVENT, 32'h3);
    wr(IDX_CNT, 32'h0);
    wr(IDX_REF, 32'h0);
    wr(IDX_XMODE, 32'h80);
    wr(IDX_MODE, 32'h11);
    dm_en <= 1'b1;
    tk(1);
    chk("dma up", dreq, 32'h1);
    chk("no irq", irq, 32'h0);
    repeat (6) @(posedge clk);
    chk("dma down", dreq, 32'h0);
    rd(IDX_EVENT);
    chk("ack clr", rdat, 32'h0);
    // mid-run reset puts the registers back
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("cnt rst", cnt, 32'h0);
    rd(IDX_XMODE);
    chk("xmode rst2", rdat, 32'h0);
    rd(IDX_REF);
    chk("ref rst2", rdat, RST_REF);
    results;
  end
endmodule
`default_nettype wire
